// ==== core/pwm_dac_params.svh ====
// Offsets, field positions, reset values and timing counts
`ifndef PWM_DAC_PARAMS_SVH
`define PWM_DAC_PARAMS_SVH

// Register indices; byte address is four times the index
`define CH0_IDX 10'h0E0
`define CH1_IDX 10'h0E1
`define CH2_IDX 10'h0E2
`define CH3_IDX 10'h0E3
`define STATUS_IDX 10'h0F0

// Bus address width
`define AXI_ADDR_W 12

// Channel register fields
`define VAL_MSB 5
`define EN_BIT 6
`define TOP_BIT 7

// Status register fields
`define ST_CNT_MSB 5
`define ST_AUX_BIT 6
`define ST_PHASE_BIT 7
`define ST_PIN_LSB 8
`define ST_AUX_PIN_BIT 12

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

// Register reset value
`define CH_RESET 8'h00

// Timing
`define CLK_HZ 20000000
`define PWM_RATE_HZ 32500
`define SQW_HZ 62500
`define PWM_STEPS 64
`define PREDIV_CYC (`CLK_HZ / (`PWM_RATE_HZ * `PWM_STEPS))
`define SQW_HALF_CYC (`CLK_HZ / (2 * `SQW_HZ))

`endif

// ==== core/pwm_dac_pkg.sv ====
// Types shared by the PWM converter block
`include "pwm_dac_params.svh"

package pwm_dac_pkg;

    // Write channel states, one-hot
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    typedef logic [`AXI_ADDR_W-1:0] addr_t;

    // Whole block state
    typedef struct packed {
        logic [3:0][7:0] ch;
        logic [7:0] pre_cnt;
        logic [5:0] pwm_cnt;
        logic [8:0] sq_cnt;
        logic sq_phase;
        logic [3:0] pwm_lvl;
        logic aux_lvl;
        wr_state_e wr;
        logic aw_got;
        addr_t awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } blk_s;

endpackage : pwm_dac_pkg

// ==== core/pwm_dac_and_clock_output.sv ====
// Four-channel PWM converter with square-wave aux output
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pwm_dac_params.svh"

module pwm_dac_and_clock_output #(
    // Counter step divider
    parameter logic [7:0] PREDIV = 8'(`PREDIV_CYC),
    // Square wave half period
    parameter logic [8:0] SQW_HALF = 9'(`SQW_HALF_CYC)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pwm_dac_pkg::addr_t awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire pwm_dac_pkg::addr_t araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [3:0] pwm_outputs_in,
    output logic [3:0] pwm_outputs_out,
    output logic [3:0] pwm_outputs_oe,
    input wire logic aux_output_in,
    output logic aux_output_out,
    output logic aux_output_oe,
    output logic ext_irq_enable,
    output logic comparator_ref_shift
);
    import pwm_dac_pkg::*;

    // Select code for no mapped register
    localparam logic [2:0] SEL_NONE = 3'h7;
    // Select code for the status register
    localparam logic [2:0] SEL_STAT = 3'h4;

    // Current state
    blk_s s_reg;
    // Next state
    blk_s s_next;
    // Prescaler wrap
    logic pre_tick;
    // Half period of square wave done
    logic sq_tick;
    // Decoded write target
    logic [2:0] wsel;
    // Decoded read target
    logic [2:0] rsel;

    // Maps a byte address onto a register select code
    function automatic logic [2:0] reg_sel(input addr_t a);
        logic [2:0] r;
        r = SEL_NONE;
        if (a[1:0] == 2'h0) begin
            case (a[`AXI_ADDR_W-1:2])
                `CH0_IDX: r = 3'h0;
                `CH1_IDX: r = 3'h1;
                `CH2_IDX: r = 3'h2;
                `CH3_IDX: r = 3'h3;
                `STATUS_IDX: r = SEL_STAT;
                default: r = SEL_NONE;
            endcase
        end
        return r;
    endfunction : reg_sel

    // Read data for a select code
    function automatic logic [31:0] read_word(input blk_s s, input logic [2:0] sel,
            input logic [3:0] pin, input logic apin);
        logic [31:0] d;
        d = 32'h0;
        case (sel)
            3'h0, 3'h1, 3'h3: begin
                d[7:0] = s.ch[sel[1:0]];
            end
            3'h2: begin
                d[6:0] = s.ch[2][6:0];
            end
            SEL_STAT: begin
                d[`ST_CNT_MSB:0] = s.pwm_cnt;
                d[`ST_AUX_BIT] = s.aux_lvl;
                d[`ST_PHASE_BIT] = s.sq_phase;
                d[`ST_PIN_LSB+3:`ST_PIN_LSB] = pin;
                d[`ST_AUX_PIN_BIT] = apin;
            end
            default: d = 32'h0;
        endcase
        return d;
    endfunction : read_word

    // Wrap strobes for the two dividers
    assign pre_tick = (s_reg.pre_cnt == PREDIV - 8'h01);
    assign sq_tick = (s_reg.sq_cnt == SQW_HALF - 9'h001);
    assign rsel = reg_sel(araddr);

    // Next-state logic for counters, outputs and bus
    always_comb begin
        s_next = s_reg;
        wsel = SEL_NONE;

        if (pre_tick) begin
            s_next.pre_cnt = 8'h00;
            s_next.pwm_cnt = s_reg.pwm_cnt + 6'h01;
        end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 8'h01;
        end

        if (sq_tick) begin
            s_next.sq_cnt = 9'h000;
            s_next.sq_phase = ~s_reg.sq_phase;
        end else begin
            s_next.sq_cnt = s_reg.sq_cnt + 9'h001;
        end

        // Compare each channel against shared counter
        for (int i = 0; i < 4; i++) begin
            // High while count at or above N
            // N of zero never goes low
            // N of all ones high on last count only
            // Zero value leaves the enable in charge
            s_next.pwm_lvl[i] = s_reg.ch[i][`EN_BIT]
                && (s_reg.pwm_cnt >= s_reg.ch[i][`VAL_MSB:0]);
        end

        s_next.aux_lvl = s_reg.ch[0][`TOP_BIT] ? s_reg.sq_phase
            : s_reg.ch[1][`TOP_BIT];

        // Write address and data taken in either order
        case (s_reg.wr)
            WR_COLLECT: begin
                if (awvalid && !s_reg.aw_got) begin
                    s_next.aw_got = 1'b1;
                    s_next.awaddr = awaddr;
                end
                if (wvalid && !s_reg.w_got) begin
                    s_next.w_got = 1'b1;
                    s_next.wdata = wdata[7:0];
                    s_next.wstrb0 = wstrb[0];
                end
                // Both halves in hand: commit
                if (s_next.aw_got && s_next.w_got) begin
                    wsel = reg_sel(s_next.awaddr);
                    if (wsel < SEL_STAT && s_next.wstrb0) begin
                        s_next.ch[wsel[1:0]] = s_next.wdata;
                    end
                    // Status writes are ignored quietly
                    s_next.bresp = (wsel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
                    s_next.aw_got = 1'b0;
                    s_next.w_got = 1'b0;
                    s_next.wr = WR_RESP;
                end
            end
            WR_RESP: begin
                // Response holds until taken
                if (bready) begin
                    s_next.wr = WR_COLLECT;
                end
            end
            default: begin
                s_next.wr = WR_COLLECT;
            end
        endcase

        // Read channel, one outstanding
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = read_word(s_reg, rsel, pwm_outputs_in, aux_output_in);
            s_next.rresp = (rsel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Cleared anyway, for a known start
            s_reg <= '0;
            s_reg.ch <= {4{`CH_RESET}};
            s_reg.wr <= WR_COLLECT;
        end else begin
            s_reg <= s_next;
        end
    end

    // Bus handshakes, combinational from state
    assign awready = (s_reg.wr == WR_COLLECT) && !s_reg.aw_got;
    assign wready = (s_reg.wr == WR_COLLECT) && !s_reg.w_got;
    assign bvalid = (s_reg.wr == WR_RESP);
    assign bresp = s_reg.bresp;
    assign arready = !s_reg.rvalid;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;

    // Open-drain pins only ever pull low
    // Pins set by enable and data bits
    assign pwm_outputs_out = 4'h0;
    assign pwm_outputs_oe = ~s_reg.pwm_lvl;
    assign aux_output_out = 1'b0;
    assign aux_output_oe = ~s_reg.aux_lvl;

    // Interrupt gate to the interrupt unit and comparator reference shift
    assign ext_irq_enable = s_reg.ch[2][`TOP_BIT];
    assign comparator_ref_shift = s_reg.ch[3][`TOP_BIT];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Zero value while enabled drives high
    zero_high_a: assert property (
        s_reg.ch[0][`EN_BIT] && s_reg.ch[0][`VAL_MSB:0] == 6'h00 |=> s_reg.pwm_lvl[0])
        else $error("enabled zero channel not high");

    // Disabled channel stays low
    disable_low_a: assert property (
        !s_reg.ch[1][`EN_BIT] |=> !s_reg.pwm_lvl[1])
        else $error("disabled channel not low");

    // All ones high only at last count
    ones_pulse_a: assert property (
        s_reg.ch[2] [`EN_BIT:0] == 7'h7F
        |=> s_reg.pwm_lvl[2] == ($past(s_reg.pwm_cnt) == 6'h3F))
        else $error("full-scale pulse wrong");

    // Duty follows compare against count
    duty_compare_a: assert property (
        s_reg.ch[3][`EN_BIT]
        |=> s_reg.pwm_lvl[3] == ($past(s_reg.pwm_cnt) >= $past(s_reg.ch[3][`VAL_MSB:0])))
        else $error("channel duty mismatch");

    // Counter steps only on prescaler wrap
    counter_step_a: assert property (
        pre_tick |=> s_reg.pwm_cnt == $past(s_reg.pwm_cnt) + 6'h01)
        else $error("counter missed a step");

    // Counter holds between wraps
    counter_hold_a: assert property (
        !pre_tick |=> $stable(s_reg.pwm_cnt))
        else $error("counter moved without tick");

    // Square phase toggles at half period
    square_toggle_a: assert property (
        sq_tick |=> s_reg.sq_phase != $past(s_reg.sq_phase))
        else $error("square wave did not toggle");

    // Aux follows data bit when unselected
    aux_data_a: assert property (
        !s_reg.ch[0][`TOP_BIT] |=> s_reg.aux_lvl == $past(s_reg.ch[1][`TOP_BIT]))
        else $error("aux not following data bit");

    // Aux follows phase when selected
    aux_square_a: assert property (
        s_reg.ch[0][`TOP_BIT] |=> s_reg.aux_lvl == $past(s_reg.sq_phase))
        else $error("aux not following square wave");

    // Read of channel two hides bit seven
    irq_hidden_a: assert property (
        arvalid && arready && rsel == 3'h2 |=> !rdata[`TOP_BIT])
        else $error("write-only bit visible");

    // Write answered one cycle after commit
    write_resp_a: assert property (
        s_reg.wr == WR_COLLECT && s_next.wr == WR_RESP |=> bvalid)
        else $error("write response late");

    // Counter step divider stays inside its span
    prescale_range_a: assert property (
        s_reg.pre_cnt < PREDIV)
        else $error("prescaler out of range");

    // Half-period divider never overruns, so halves stay equal
    square_range_a: assert property (
        s_reg.sq_cnt < SQW_HALF)
        else $error("square divider out of range");

    // Read answered one cycle after it is taken
    read_resp_a: assert property (
        arvalid && arready |=> rvalid)
        else $error("read response late");

    // Write response holds until taken
    write_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    // Read data holds until taken
    read_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");

    // Committed write to channel two reaches the interrupt gate
    irq_write_a: assert property (
        s_next.wr == WR_RESP && s_reg.wr == WR_COLLECT && wsel == 3'h2 && s_next.wstrb0
        |=> ext_irq_enable == $past(s_next.wdata[`TOP_BIT]))
        else $error("interrupt enable not written");

    // Committed write to channel three reaches the comparator
    ref_write_a: assert property (
        s_next.wr == WR_RESP && s_reg.wr == WR_COLLECT && wsel == 3'h3 && s_next.wstrb0
        |=> comparator_ref_shift == $past(s_next.wdata[`TOP_BIT]))
        else $error("reference shift not written");

    // Disabled channel pulls its pin low
    pin_pull_a: assert property (
        !s_reg.ch[0][`EN_BIT] |=> pwm_outputs_oe[0])
        else $error("disabled pin released");

endmodule : pwm_dac_and_clock_output

// ==== bench/rc_filter_load.sv ====
// Far-side load model: pull-ups feeding the external RC filters
`timescale 1ns/100ps

module rc_filter_load (
    input wire logic [3:0] pwm_oe,
    input wire logic aux_oe,
    output logic [3:0] pwm_pin,
    output logic aux_pin
);
    // Pull-up wins whenever the device lets go of a line
    assign pwm_pin = ~pwm_oe;
    assign aux_pin = ~aux_oe;
endmodule : rc_filter_load

// ==== bench/testbench.sv ====
// Self-checking bench for the PWM converter block
`timescale 1ns/100ps
`include "pwm_dac_params.svh"

module testbench;
    import pwm_dac_pkg::*;
    localparam int PD = 2; // Short counter step keeps runs brief
    localparam int SQ = 4; // Short square half period
    localparam int PER = 64 * PD; // Cycles in one PWM period
    localparam addr_t STAT_A = addr_t'(`STATUS_IDX * 4); // Status byte address
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    addr_t awaddr = '0;
    addr_t araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, aux_out, aux_oe, aux_pin, irq_en, ref_sh;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] pwm_out, pwm_oe, pwm_pin;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;

    pwm_dac_and_clock_output #(.PREDIV(8'(PD)), .SQW_HALF(9'(SQ))) uut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pwm_outputs_in(pwm_pin),
        .pwm_outputs_out(pwm_out), .pwm_outputs_oe(pwm_oe), .aux_output_in(aux_pin),
        .aux_output_out(aux_out), .aux_output_oe(aux_oe), .ext_irq_enable(irq_en),
        .comparator_ref_shift(ref_sh));

    rc_filter_load load (.pwm_oe(pwm_oe), .aux_oe(aux_oe), .pwm_pin(pwm_pin), .aux_pin(aux_pin));

    // 20 MHz clock
    always #25 aclk = ~aclk;

    // Hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bus write; bready is offered up front and held until the answer
    task automatic wr(input addr_t a, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        if (n == 50) n_mismatch++;
    endtask : wr

    // Bus read; the mask picks the bits that are judged
    task automatic rd_m(input addr_t a, input logic [31:0] m, input logic [31:0] ed,
            input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        chk(32'(rresp), 32'(er));
        chk(rdata & m, ed);
        if (n == 50) n_mismatch++;
    endtask : rd_m

    task automatic rd(input addr_t a, input logic [31:0] ed, input logic [1:0] er);
        rd_m(a, 32'hFFFFFFFF, ed, er);
    endtask : rd

    function automatic addr_t ch(input int i);
        return addr_t'((`CH0_IDX + i) * 4);
    endfunction : ch

    // High cycles per pin over exactly one PWM period, plus aux edges
    task automatic measure(output int hi[4], output int ahi, output int aed);
        logic prev;
        hi = '{0, 0, 0, 0};
        ahi = 0;
        aed = 0;
        repeat (4) @(posedge aclk);
        prev = aux_pin;
        for (int i = 0; i < PER; i++) begin
            @(posedge aclk);
            for (int c = 0; c < 4; c++) hi[c] += int'(pwm_pin[c] === 1'b1);
            ahi += int'(aux_pin === 1'b1);
            aed += int'(aux_pin !== prev);
            prev = aux_pin;
        end
    endtask : measure

    task automatic t_reset();
        chk(32'({pwm_pin, aux_pin, irq_en, ref_sh}), 32'h0);
        chk(32'({pwm_out, aux_out}), 32'h0);
        rd(ch(0), 32'(`CH_RESET), `RESP_OKAY);
    endtask : t_reset

    // Duty for each loaded value, all four pins on one shared count
    task automatic t_levels();
        logic [7:0] v[2][4] = '{'{8'h40, 8'h7F, 8'h3F, 8'h54}, '{8'h00, 8'h41, 8'h60, 8'h7E}};
        int hi[4];
        int ahi, aed;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 4; c++) wr(ch(c), v[r][c], `RESP_OKAY);
            measure(hi, ahi, aed);
            for (int c = 0; c < 4; c++) begin
                chk(32'(hi[c]), v[r][c][6] ? 32'((64 - v[r][c][5:0]) * PD) : 32'h0);
            end
            chk(32'(ahi), 32'h0);
        end
    endtask : t_levels

    // Aux pin: data bit, then square wave, then both off
    task automatic t_aux();
        int hi[4];
        int ahi, aed;
        wr(ch(1), 8'h80, `RESP_OKAY);
        measure(hi, ahi, aed);
        chk(32'(ahi), 32'(PER));
        wr(ch(0), 8'h80, `RESP_OKAY);
        measure(hi, ahi, aed);
        chk(32'(ahi), 32'(PER / 2));
        chk(32'(aed), 32'(PER / SQ));
        wr(ch(0), 8'h00, `RESP_OKAY);
        wr(ch(1), 8'h00, `RESP_OKAY);
        measure(hi, ahi, aed);
        chk(32'(ahi + hi[0] + hi[1]), 32'h0);
    endtask : t_aux

    // Passed-out control bits, write-only bit, unmapped place
    task automatic t_side();
        wr(ch(2), 8'h80, `RESP_OKAY);
        wr(ch(3), 8'h80, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'({irq_en, ref_sh}), 32'h3);
        rd(ch(2), 32'h0, `RESP_OKAY);
        rd(ch(3), 32'h80, `RESP_OKAY);
        wr(ch(2), 8'h00, `RESP_OKAY);
        wr(ch(3), 8'h00, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'({irq_en, ref_sh}), 32'h0);
        wr(12'h004, 8'h55, `RESP_DECERR);
        rd(12'h004, 32'h0, `RESP_DECERR);
    endtask : t_side

    // Status shows pin levels; status and masked writes change nothing
    task automatic t_status();
        wr(ch(0), 8'h40, `RESP_OKAY);
        wr(ch(1), 8'h80, `RESP_OKAY);
        repeat (4) @(posedge aclk);
        rd_m(STAT_A, 32'h00001F40, 32'h00001140, `RESP_OKAY);
        wr(STAT_A, 8'hFF, `RESP_OKAY);
        wstrb <= 4'h0;
        wr(ch(0), 8'h00, `RESP_OKAY);
        wstrb <= 4'hF;
        rd(ch(0), 32'h40, `RESP_OKAY);
    endtask : t_status

    // Main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_levels();
        t_aux();
        t_side();
        t_status();
        wrap_up();
    end
endmodule : testbench
